// file: verilog/io_region_pkg.sv
package io_region_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [11:0] REGION3_LOWER_BOUND_CTRL_OFS = 12'h730;
   localparam logic [11:0] REGION3_UPPER_BOUND_OFS      = 12'h728;
   localparam logic [11:0] REGION4_LOWER_BOUND_CTRL_OFS = 12'h740;
   localparam logic [11:0] REGION4_UPPER_BOUND_OFS      = 12'h748;
   localparam logic [11:0] REGION5_LOWER_BOUND_CTRL_OFS = 12'h750;
   localparam logic [11:0] REGION5_UPPER_BOUND_OFS      = 12'h758;
   localparam logic [11:0] REGION6_LOWER_BOUND_CTRL_OFS = 12'h760;
   localparam logic [11:0] REGION6_UPPER_BOUND_OFS      = 12'h768;
   localparam logic [11:0] REGION7_LOWER_BOUND_CTRL_OFS = 12'h770;
   localparam logic [11:0] REGION7_UPPER_BOUND_OFS      = 12'h778;

   localparam int FIRST_REGION = 3;
   localparam int LAST_REGION  = 7;
   localparam int NUM_REGIONS  = LAST_REGION - FIRST_REGION + 1;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int BOUND_LSB    = 16;
   localparam int BOUND_MSB    = 47;
   localparam int BOUND_W      = BOUND_MSB - BOUND_LSB + 1;
   localparam int ATTR_LSB     = 8;
   localparam int NONCOH_BIT   = 6;
   localparam int PORT_LSB     = 2;
   localparam int EXEMPT_BIT   = 1;
   localparam int ENABLE_BIT   = 0;

   // ----------------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------------
   localparam logic [1:0] QUAL_ANY      = 2'h0;
   localparam logic [1:0] QUAL_UC       = 2'h1;
   localparam logic [1:0] QUAL_UCA      = 2'h2;
   localparam logic [1:0] QUAL_UC_UCA   = 2'h3;
   localparam logic [3:0] PORT_MAIN     = 4'h0;
   localparam logic [3:0] PORT_SIDE_0   = 4'h8;
   localparam logic [3:0] PORT_SIDE_3   = 4'hb;

   typedef enum logic [2:0] {
      DEST_NONE   = 3'b000,
      DEST_MAIN   = 3'b001,
      DEST_SIDE_0 = 3'b100,
      DEST_SIDE_1 = 3'b101,
      DEST_SIDE_2 = 3'b110,
      DEST_SIDE_3 = 3'b111
   } dest_t;

endpackage : io_region_pkg

// file: verilog/io_region_decoder.sv
`timescale 1ns/1ps
module io_region_decoder
   import io_region_pkg::*;
#(
   parameter int                    CONFIGURED_REGION_COUNT = 8,
   parameter logic [NUM_REGIONS*64-1:0] LOWER_RESET         = '0,
   parameter logic [NUM_REGIONS*64-1:0] UPPER_RESET         = '0
) (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] reg_addr,
   input  wire logic [63:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [63:0] reg_rdata,
   input  wire logic        req_valid,
   input  wire logic [47:0] req_addr,
   input  wire logic        req_coherent,
   input  wire logic        cache_coherency_attribute_uc,
   input  wire logic        cache_coherency_attribute_uca,
   output logic             region_hit,
   output logic [2:0]       region_index,
   output logic [2:0]       req_dest,
   output logic             req_reserved_port,
   output logic             req_noncoherent,
   output logic             limit_exempt,
   output logic [3:0]       request_limit_setting_apply
);

   // ----------------------------------------------------------------------
   // Masks of implemented bits
   // ----------------------------------------------------------------------
   localparam logic [63:0] LOWER_MASK = 64'h0000_ffff_ffff_037f;
   localparam logic [63:0] UPPER_MASK = 64'h0000_ffff_ffff_0000;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic region_present(input int idx);
      return CONFIGURED_REGION_COUNT > (idx + FIRST_REGION);
   endfunction : region_present

   function automatic logic attr_ok(input logic [1:0] qual, input logic uc,
                                    input logic uncached_accelerated_attr);
      logic ok;
      ok = 1'b0;
      unique case (qual)
         QUAL_ANY:    ok = 1'b1;
         QUAL_UC:     ok = uc;
         QUAL_UCA:    ok = uncached_accelerated_attr;
         QUAL_UC_UCA: ok = uc | uncached_accelerated_attr;
      endcase
      return ok;
   endfunction : attr_ok

   function automatic logic [2:0] lower_index(input logic [11:0] a);
      return a[6:4] - 3'h3;
   endfunction : lower_index

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic [63:0] lower_reg [NUM_REGIONS];
   logic [63:0] upper_reg [NUM_REGIONS];

   logic        is_lower;
   logic        is_upper;
   logic [2:0]  sel;

   always_comb begin
      is_lower = 1'b0;
      is_upper = 1'b0;
      sel      = 3'h0;
      unique case (reg_addr)
         REGION3_LOWER_BOUND_CTRL_OFS,
         REGION4_LOWER_BOUND_CTRL_OFS,
         REGION5_LOWER_BOUND_CTRL_OFS,
         REGION6_LOWER_BOUND_CTRL_OFS,
         REGION7_LOWER_BOUND_CTRL_OFS: begin
            is_lower = 1'b1;
            sel      = lower_index(reg_addr);
         end
         REGION3_UPPER_BOUND_OFS: begin
            is_upper = 1'b1;
            sel      = 3'h0;
         end
         REGION4_UPPER_BOUND_OFS,
         REGION5_UPPER_BOUND_OFS,
         REGION6_UPPER_BOUND_OFS,
         REGION7_UPPER_BOUND_OFS: begin
            is_upper = 1'b1;
            sel      = lower_index(reg_addr);
         end
         default: begin
            is_lower = 1'b0;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Write enables
   // ----------------------------------------------------------------------
   logic [NUM_REGIONS-1:0] lower_wr;
   logic [NUM_REGIONS-1:0] upper_wr;

   always_comb begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
         lower_wr[i] = reg_wr && is_lower && sel == 3'(i) && region_present(i);
         upper_wr[i] = reg_wr && is_upper && sel == 3'(i) && region_present(i);
      end
   end

   // ----------------------------------------------------------------------
   // Lower bound and control words
   // ----------------------------------------------------------------------
   // One process owns the whole array, so no element has two drivers
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
         if (!region_present(i)) begin
            lower_reg[i] <= 64'h0;
         end else if (sys_rst) begin
            lower_reg[i] <= LOWER_RESET[i*64 +: 64] & LOWER_MASK;
         end else if (lower_wr[i]) begin
            lower_reg[i] <= reg_wdata & LOWER_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Upper bound words
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
         if (!region_present(i)) begin
            upper_reg[i] <= 64'h0;
         end else if (sys_rst) begin
            upper_reg[i] <= UPPER_RESET[i*64 +: 64] & UPPER_MASK;
         end else if (upper_wr[i]) begin
            upper_reg[i] <= reg_wdata & UPPER_MASK;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Field views
   // ----------------------------------------------------------------------
   logic [BOUND_W-1:0] region_low_bound      [NUM_REGIONS];
   logic [BOUND_W-1:0] region_high_bound     [NUM_REGIONS];
   logic [1:0]         region_attr_qualifier [NUM_REGIONS];
   logic               force_noncoherent     [NUM_REGIONS];
   logic [3:0]         region_port_select    [NUM_REGIONS];
   logic               region_limit_exempt   [NUM_REGIONS];
   logic               region_enable         [NUM_REGIONS];

   always_comb begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
         region_low_bound[i]      = lower_reg[i][BOUND_MSB:BOUND_LSB];
         region_high_bound[i]     = upper_reg[i][BOUND_MSB:BOUND_LSB];
         region_attr_qualifier[i] = lower_reg[i][ATTR_LSB +: 2];
         force_noncoherent[i]     = lower_reg[i][NONCOH_BIT];
         region_port_select[i]    = lower_reg[i][PORT_LSB +: 4];
         region_limit_exempt[i]   = lower_reg[i][EXEMPT_BIT];
         region_enable[i]         = lower_reg[i][ENABLE_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= 64'h0;
      end else if (reg_rd && is_lower && region_present(int'(sel))) begin
         reg_rdata <= lower_reg[sel];
      end else if (reg_rd && is_upper && region_present(int'(sel))) begin
         reg_rdata <= upper_reg[sel];
      end else begin
         reg_rdata <= 64'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   logic [BOUND_W-1:0]     page;
   logic [NUM_REGIONS-1:0] in_range;
   logic [NUM_REGIONS-1:0] attr_match;
   logic [NUM_REGIONS-1:0] hits;
   logic [2:0]             win_sel;
   logic [3:0]             win_port;
   logic                   win_noncoh;
   logic                   win_exempt;

   assign page = req_addr[BOUND_MSB:BOUND_LSB];

   always_comb begin
      for (int i = 0; i < NUM_REGIONS; i++) begin
         in_range[i]   = page >= region_low_bound[i]
                      && page <= region_high_bound[i];
         attr_match[i] = attr_ok(region_attr_qualifier[i],
                                 cache_coherency_attribute_uc,
                                 cache_coherency_attribute_uca);
         hits[i]       = req_valid && region_present(i) && region_enable[i]
                      && in_range[i] && attr_match[i];
      end
   end

   // ----------------------------------------------------------------------
   // Winner select
   // ----------------------------------------------------------------------
   // Lowest-numbered matching region wins on overlap
   function automatic logic [2:0] lowest_set(input logic [NUM_REGIONS-1:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NUM_REGIONS - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : lowest_set

   assign win_sel      = lowest_set(hits);
   assign region_hit   = |hits;
   assign region_index = region_hit ? win_sel + 3'(FIRST_REGION) : 3'h0;
   assign win_port     = region_port_select[win_sel];
   assign win_noncoh   = force_noncoherent[win_sel];
   assign win_exempt   = region_limit_exempt[win_sel];

   always_comb begin
      req_dest          = DEST_NONE;
      req_reserved_port = 1'b0;
      if (region_hit) begin
         if (win_port == PORT_MAIN) begin
            req_dest = DEST_MAIN;
         end else if (win_port >= PORT_SIDE_0 && win_port <= PORT_SIDE_3) begin
            req_dest = {1'b1, win_port[1:0]};
         end else begin
            req_reserved_port = 1'b1;
         end
      end
   end

   assign req_noncoherent = region_hit & req_coherent & win_noncoh;
   assign limit_exempt    = region_hit & win_exempt;
   // Command type, attribute and count limits apply only on a region hit that is not exempt
   assign request_limit_setting_apply = {4{region_hit & ~win_exempt}};

endmodule : io_region_decoder

// file: testbench/io_region_checker.sv
`timescale 1ns/1ps
module io_region_checker
   import io_region_pkg::*;
#(
   parameter int CONFIGURED_REGION_COUNT = 8
) (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic [11:0] reg_addr,
   input wire logic        reg_rd,
   input wire logic [63:0] reg_rdata,
   input wire logic        req_coherent,
   input wire logic        region_hit,
   input wire logic [2:0]  region_index,
   input wire logic [2:0]  req_dest,
   input wire logic        req_reserved_port,
   input wire logic        req_noncoherent,
   input wire logic        limit_exempt,
   input wire logic [3:0]  request_limit_setting_apply
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   sequence rd_low; reg_rd && !reg_addr[3]; endsequence
   sequence rd_up; reg_rd && reg_addr[3]; endsequence
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 64'h0)
      else $error("read data outside read cycle");
   low_resv_a: assert property (rd_low |=> reg_rdata[63:48] == 0 && reg_rdata[15:10] == 0)
      else $error("lower register reserved bits");
   up_resv_a: assert property (rd_up |=> reg_rdata[63:48] == 0 && reg_rdata[15:0] == 0)
      else $error("upper register reserved bits");
   miss_quiet_a: assert property (!region_hit |-> req_dest == DEST_NONE && !req_reserved_port)
      else $error("route without hit");
   hit_route_a: assert property (region_hit && !req_reserved_port |-> req_dest != DEST_NONE)
      else $error("hit without route");
   index_range_a: assert property (region_hit |-> region_index >= 3
      && region_index < CONFIGURED_REGION_COUNT)
      else $error("hit on absent region");
   noncoh_src_a: assert property (req_noncoherent |-> region_hit && req_coherent)
      else $error("noncoherent without coherent hit");
   limit_apply_a: assert property (region_hit |->
      request_limit_setting_apply == {4{!limit_exempt}})
      else $error("limit apply mismatch");
endmodule : io_region_checker

// file: testbench/req_source.sv
`timescale 1ns/1ps
module req_source (
   input  wire logic core_clk,
   output logic      req_valid,
   output logic [47:0] req_addr,
   output logic      req_coherent,
   output logic      cache_coherency_attribute_uc,
   output logic      cache_coherency_attribute_uca
);
   initial begin
      req_valid = 1'b0;
      req_addr = '0;
      req_coherent = 1'b0;
      cache_coherency_attribute_uc = 1'b0;
      cache_coherency_attribute_uca = 1'b0;
   end
   task automatic issue(input logic [47:0] a, input logic uc, input logic uncached_accelerated_attr, input logic coh);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_addr <= a;
      req_coherent <= coh;
      cache_coherency_attribute_uc <= uc;
      cache_coherency_attribute_uca <= uncached_accelerated_attr;
   endtask : issue
endmodule : req_source

// file: testbench/io_region_decoder_test.sv
`timescale 1ns/1ps
module io_region_decoder_test;
   import io_region_pkg::*;
   localparam logic [63:0] LMASK = 64'h0000ffffffff037f;
   localparam logic [63:0] UMASK = 64'h0000ffffffff0000;
   localparam logic [63:0] U3RST = 64'hffff00001234abcd;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] reg_addr = '0;
   logic [63:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [63:0] reg_rdata;
   logic req_valid, req_coherent, cache_coherency_attribute_uc, cache_coherency_attribute_uca;
   logic [47:0] req_addr;
   logic region_hit, req_reserved_port, req_noncoherent, limit_exempt;
   logic [2:0] region_index, req_dest;
   logic [3:0] request_limit_setting_apply;
   int n_mismatch = 0;
   int n_tests = 0;
   int cycles = 0;
   io_region_decoder #(
      .CONFIGURED_REGION_COUNT(7),
      .UPPER_RESET({256'h0, U3RST})
   ) u_dut (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .req_valid(req_valid),
      .req_addr(req_addr),
      .req_coherent(req_coherent),
      .cache_coherency_attribute_uc(cache_coherency_attribute_uc),
      .cache_coherency_attribute_uca(cache_coherency_attribute_uca),
      .region_hit(region_hit),
      .region_index(region_index),
      .req_dest(req_dest),
      .req_reserved_port(req_reserved_port),
      .req_noncoherent(req_noncoherent),
      .limit_exempt(limit_exempt),
      .request_limit_setting_apply(request_limit_setting_apply)
   );
   req_source u_src (
      .core_clk(core_clk),
      .req_valid(req_valid),
      .req_addr(req_addr),
      .req_coherent(req_coherent),
      .cache_coherency_attribute_uc(cache_coherency_attribute_uc),
      .cache_coherency_attribute_uca(cache_coherency_attribute_uca)
   );
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [63:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [63:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", e, reg_rdata);
   endtask : rd
   task automatic t_regs;
      logic [11:0] o;
      rd(REGION3_UPPER_BOUND_OFS, U3RST & UMASK);
      rd(REGION4_LOWER_BOUND_CTRL_OFS, 64'h0);
      for (int i = 0; i < 10; i++) begin
         o = (i == 0) ? REGION3_UPPER_BOUND_OFS : 12'h730 + 12'(i) * 12'h8;
         if (i == 1) o = REGION3_LOWER_BOUND_CTRL_OFS;
         wr(o, '1);
         rd(o, (i >= 8) ? 64'h0 : (o[3] ? UMASK : LMASK));
      end
      wr(12'h700, '1);
      rd(12'h700, 64'h0);
      $display("register test done");
   endtask : t_regs
   task automatic dec(input logic [9:0] c, input logic [47:0] a, input logic [1:0] at,
                      input logic coh, input logic hit, input logic res);
      wr(REGION4_LOWER_BOUND_CTRL_OFS, {48'h1, 6'h0, c});
      u_src.issue(a, at[1], at[0], coh);
      #1;
      chk("hit", 64'(hit), 64'(region_hit));
      chk("reserved port", 64'(res), 64'(req_reserved_port));
      chk("noncoherent", 64'(hit & coh & c[6]), 64'(req_noncoherent));
      if (hit) begin
         chk("index", 64'h4, 64'(region_index));
         chk("exempt", 64'(c[1]), 64'(limit_exempt));
         chk("apply", 64'({4{!c[1]}}), 64'(request_limit_setting_apply));
         if (!res) chk("dest", 64'((c[5:2] == PORT_MAIN) ? DEST_MAIN : {1'b1, c[3:2]}), 64'(req_dest));
      end
   endtask : dec
   task automatic t_decode;
      wr(REGION4_UPPER_BOUND_OFS, 64'h0000000000020000);
      dec(10'h000, 48'h10000, 2'b00, 1'b0, 1'b0, 1'b0);
      dec(10'h001, 48'h10000, 2'b00, 1'b0, 1'b1, 1'b0);
      dec(10'h001, 48'h2ffff, 2'b00, 1'b0, 1'b1, 1'b0);
      dec(10'h001, 48'h30000, 2'b00, 1'b0, 1'b0, 1'b0);
      dec(10'h001, 48'h0ffff, 2'b00, 1'b0, 1'b0, 1'b0);
      for (int q = 0; q < 4; q++) begin
         for (int t = 0; t < 3; t++) begin
            dec({q[1:0], 8'h01}, 48'h18000, t[1:0], 1'b0,
                q == 0 || (q[0] && t[1]) || (q[1] && t[0]), 1'b0);
         end
      end
      for (int p = 0; p < 16; p++) begin
         dec({4'h0, p[3:0], 2'b01}, 48'h20000, 2'b00, 1'b0, 1'b1, !(p == 0 || p inside {[8:11]}));
      end
      dec(10'h041, 48'h20000, 2'b00, 1'b1, 1'b1, 1'b0);
      dec(10'h041, 48'h20000, 2'b00, 1'b0, 1'b1, 1'b0);
      dec(10'h003, 48'h20000, 2'b00, 1'b1, 1'b1, 1'b0);
      $display("decode test done");
   endtask : t_decode
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_decode();
      finish_test();
   end
endmodule : io_region_decoder_test
bind io_region_decoder io_region_checker #(.CONFIGURED_REGION_COUNT(CONFIGURED_REGION_COUNT)) u_chk (.*);
